// ==== shared/pmhs_map.svh ====
// Register offsets, field positions, reset values and timing constants of the sequencer host
`ifndef PMHS_MAP_SVH
`define PMHS_MAP_SVH
// ==================================================
// Own register map (byte addresses on APB)
`define PMHS_CTRL_OFS        8'h00
`define PMHS_STATUS_OFS      8'h04
`define PMHS_EVENT_OFS       8'h08
`define PMHS_XFER_OFS        8'h0C
// ==================================================
// CTRL fields
`define PMHS_CTRL_HOST_SHUTDOWN_OUT_BIT   0
`define PMHS_CTRL_WPIN_BIT   1
`define PMHS_CTRL_WRTC_BIT   2
`define PMHS_CTRL_AUTO_BIT   3
`define PMHS_CTRL_PSM_BIT    4
`define PMHS_CTRL_PWM_BIT    5
// EVENT fields (write one to clear)
`define PMHS_EV_ALARM_BIT    0
`define PMHS_EV_NACK_BIT     1
`define PMHS_EV_NOWAKE_BIT   2
`define PMHS_EV_REFUSE_BIT   3
// ==================================================
// Device register addresses and values
`define PMHS_AUX_A_REG       8'h01
`define PMHS_AUX_B_REG       8'h02
`define PMHS_CONV1_REG       8'h03
`define PMHS_CONV2_REG       8'h04
`define PMHS_CONV3_REG       8'h05
`define PMHS_AUX_OFF_VAL     8'h00
`define PMHS_CONV_PSM_VAL    8'h00
`define PMHS_CONV_PWM_VAL    8'h01
`define PMHS_DEV_ADDR        7'h5B
// ==================================================
// Timing
`define PMHS_MCLK_NS         10
`define PMHS_I2C_QUARTER_NS  625
`define PMHS_SYNC_RST        2'h0
`endif

// ==== shared/pmhs_pkg.sv ====
// Types shared by the sequencer host and its bench
package pmhs_pkg;
  // ==================================================
  // Bus carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pmhs_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pmhs_apb_rsp_t;
  // ==================================================
  // Host power state (Gray along run -> seq -> backup)
  typedef enum logic [1:0] {
    PMHS_RUN    = 2'h0,
    PMHS_SEQ    = 2'h1,
    PMHS_BACKUP = 2'h3
  } pmhs_pwr_t;
  // Serial engine state
  typedef enum logic [2:0] {
    PMHS_I_IDLE  = 3'h0,
    PMHS_I_START = 3'h1,
    PMHS_I_BITS  = 3'h3,
    PMHS_I_ACK   = 3'h2,
    PMHS_I_STOP  = 3'h6
  } pmhs_i2c_t;
  // Serial write sequence kinds
  typedef enum logic [1:0] {
    PMHS_K_MAN = 2'h0,
    PMHS_K_AUX = 2'h1,
    PMHS_K_PSM = 2'h2,
    PMHS_K_PWM = 2'h3
  } pmhs_kind_t;
endpackage

// ==== rtl/pmhs_host.sv ====
// Host-side power sequencer controller: hold line, wake logic and serial write engine
// Function
// - Host raises hold before button release
// - Hold output defaults high before start
// - Aux channels enabled only by serial writes
// - In backup, wake source raises hold
// - Power-off: aux off first, then hold
// - Shutdown command bit drives hold low
// - Wake source required before shutdown command
// - Undervoltage alarm starts software power-off
// - Clear three converter mode bits for saving
// - Saving mode late, fixed mode early
// - 7-bit address, one register, one data
`timescale 1ns/1ps
`include "pmhs_map.svh"

module pmhs_host #(
  parameter logic [6:0] DEV_ADDR = `PMHS_DEV_ADDR  // Serial slave address
) (
  input  wire logic                    mclk_i,          // System clock, 100 MHz
  input  wire logic                    rst_n_i,         // Asynchronous reset, active low
  input  wire pmhs_pkg::pmhs_apb_req_t apb_i,           // APB request
  output pmhs_pkg::pmhs_apb_rsp_t      apb_o,           // APB answer
  output logic                         host_shutdown_out_o, // Power hold drive to device
  input  wire logic                    wake_pin_i,      // External wake pin
  input  wire logic                    rtc_alarm_i,     // Same-clock alarm pulse
  input  wire logic                    alarm_interrupt_n_i, // Device interrupt pin
  input  wire logic                    system_reset_out_n_i, // Device reset output
  input  wire logic                    scl_in_i,        // Serial clock pin level
  output logic                         scl_out_o,       // Serial clock drive value
  output logic                         scl_oe_o,        // Serial clock pull low
  input  wire logic                    sda_in_i,        // Serial data pin level
  output logic                         sda_out_o,       // Serial data drive value
  output logic                         sda_oe_o         // Serial data pull low
);
  import pmhs_pkg::*;

  // ==================================================
  // Timing
  localparam int QCYC = (`PMHS_I2C_QUARTER_NS + `PMHS_MCLK_NS - 1) / `PMHS_MCLK_NS;

  // ==================================================
  // State
  typedef struct packed {
    pmhs_pwr_t   pwr;        // Power state
    logic        hold;       // Hold drive
    pmhs_apb_rsp_t rsp;      // Bus answer
    logic        en_pin;     // Wake by pin enabled
    logic        en_rtc;     // Wake by alarm enabled
    logic        en_auto;    // Alarm starts power-off
    logic        psm_on;     // Converters left in saving mode
    pmhs_kind_t  kind;       // Running sequence
    logic [1:0]  step;       // Next write index
    logic [3:0]  ev;         // Sticky events
    logic [7:0]  man_reg;    // Manual write register
    logic [7:0]  man_data;   // Manual write value
    logic [2:0]  wk_s;       // Wake sync plus edge stage
    logic [2:0]  al_s;       // Alarm sync plus edge stage
    logic [1:0]  rs_s;       // Reset sync
    logic [1:0]  sd_s;       // Data sync
    logic [1:0]  sc_s;       // Clock sync
    pmhs_i2c_t   ist;        // Serial engine state
    logic [7:0]  qcnt;       // Quarter-bit counter
    logic [1:0]  phase;      // Quarter within bit
    logic [2:0]  bitn;       // Bit within byte
    logic [1:0]  byten;      // Byte within frame
    logic [7:0]  shreg;      // Shift register
    logic [15:0] frame;      // Register and data bytes
    logic        scl_oe;     // Clock pull low
    logic        sda_oe;     // Data pull low
  } pmhs_st_t;

  pmhs_st_t q;  // Registered state
  pmhs_st_t d;  // Next state

  // ==================================================
  // Write list lookup: register and value per step
  function automatic logic [15:0] step_bytes(pmhs_kind_t k, logic [1:0] s,
                                             logic [7:0] mr, logic [7:0] md);
    logic [7:0] cr;
    cr = (s == 2'h0) ? `PMHS_CONV1_REG : (s == 2'h1) ? `PMHS_CONV2_REG : `PMHS_CONV3_REG;
    unique case (k)
      PMHS_K_MAN: step_bytes = {mr, md};
      PMHS_K_AUX: step_bytes = {((s == 2'h0) ? `PMHS_AUX_A_REG : `PMHS_AUX_B_REG),
                                `PMHS_AUX_OFF_VAL};
      PMHS_K_PSM: step_bytes = {cr, `PMHS_CONV_PSM_VAL};
      PMHS_K_PWM: step_bytes = {cr, `PMHS_CONV_PWM_VAL};
    endcase
  endfunction

  // Number of writes in each sequence
  function automatic logic [1:0] step_count(pmhs_kind_t k);
    unique case (k)
      PMHS_K_MAN: step_count = 2'h1;
      PMHS_K_AUX: step_count = 2'h2;
      default:    step_count = 2'h3;
    endcase
  endfunction

  // ==================================================
  // Next-state logic
  always_comb
  begin
    logic       acc;
    logic       wr;
    logic [5:0] idx;
    logic       tick;
    logic       done;
    logic       nack;
    logic [1:0] np;
    logic [3:0] clr;
    logic       start;
    pmhs_kind_t skind;
    acc   = 1'b0;
    wr    = 1'b0;
    idx   = 6'h00;
    tick  = 1'b0;
    done  = 1'b0;
    nack  = 1'b0;
    np    = 2'h0;
    clr   = 4'h0;
    start = 1'b0;
    skind = PMHS_K_MAN;
    d     = q;

    // Synchronisers; only the second and edge stages feed logic
    d.wk_s = {q.wk_s[1:0], wake_pin_i};
    d.al_s = {q.al_s[1:0], alarm_interrupt_n_i};
    d.rs_s = {q.rs_s[0], system_reset_out_n_i};
    d.sd_s = {q.sd_s[0], sda_in_i};
    d.sc_s = {q.sc_s[0], scl_in_i};

    // APB: one wait state, write acts at the pready edge
    acc = apb_i.psel & apb_i.penable & q.rsp.pready;
    // Unmapped or unaligned writes answer with an error and change nothing
    wr  = acc & apb_i.pwrite & (apb_i.paddr[7:4] == 4'h0) & (apb_i.paddr[1:0] == 2'h0);
    idx = apb_i.paddr[7:2];
    d.rsp.pready = apb_i.psel & apb_i.penable & ~q.rsp.pready;
    if (apb_i.psel & apb_i.penable & ~q.rsp.pready)
    begin
      // Read data and error are prepared for the answer cycle
      d.rsp.pslverr = (apb_i.paddr[7:4] != 4'h0) || (apb_i.paddr[1:0] != 2'h0);
      unique case (apb_i.paddr)
        `PMHS_CTRL_OFS:   d.rsp.prdata = {28'h0, q.en_auto, q.en_rtc, q.en_pin, 1'b0};
        `PMHS_STATUS_OFS: d.rsp.prdata = {25'h0, q.psm_on, q.al_s[1], q.rs_s[1],
                                          (q.ist != PMHS_I_IDLE), q.hold, q.pwr};
        `PMHS_EVENT_OFS:  d.rsp.prdata = {28'h0, q.ev};
        `PMHS_XFER_OFS:   d.rsp.prdata = {16'h0, q.man_reg, q.man_data};
        default:          d.rsp.prdata = 32'h0;  // Unmapped reads zero with error
      endcase
    end
    else
    begin
      d.rsp.pslverr = 1'b0;
    end

    // Register writes; commands only start from run
    if (wr && idx == 6'(`PMHS_CTRL_OFS >> 2))
    begin
      d.en_pin  = apb_i.pwdata[`PMHS_CTRL_WPIN_BIT];
      d.en_rtc  = apb_i.pwdata[`PMHS_CTRL_WRTC_BIT];
      d.en_auto = apb_i.pwdata[`PMHS_CTRL_AUTO_BIT];
      if (apb_i.pwdata[`PMHS_CTRL_HOST_SHUTDOWN_OUT_BIT])
      begin
        // No wake source means no way back from backup
        if (!(apb_i.pwdata[`PMHS_CTRL_WPIN_BIT] | apb_i.pwdata[`PMHS_CTRL_WRTC_BIT]))
          d.ev[`PMHS_EV_NOWAKE_BIT] = 1'b1;
        else
        begin
          start = 1'b1;
          skind = PMHS_K_AUX;
        end
      end
      else if (apb_i.pwdata[`PMHS_CTRL_PSM_BIT])
      begin
        start = 1'b1;
        skind = PMHS_K_PSM;
      end
      else if (apb_i.pwdata[`PMHS_CTRL_PWM_BIT])
      begin
        start = 1'b1;
        skind = PMHS_K_PWM;
      end
    end
    if (wr && idx == 6'(`PMHS_XFER_OFS >> 2))
    begin
      d.man_reg  = apb_i.pwdata[15:8];
      d.man_data = apb_i.pwdata[7:0];
      start = 1'b1;
      skind = PMHS_K_MAN;
    end
    if (wr && idx == 6'(`PMHS_EVENT_OFS >> 2))
      clr = apb_i.pwdata[3:0];
    d.ev = d.ev & ~clr;

    // Falling device interrupt: record it, optionally start power-off
    if (!q.al_s[1] && q.al_s[2])
    begin
      d.ev[`PMHS_EV_ALARM_BIT] = 1'b1;
      if (q.en_auto && q.pwr == PMHS_RUN && !start && (q.en_pin | q.en_rtc))
      begin
        start = 1'b1;
        skind = PMHS_K_AUX;
      end
    end

    // ------------------------------------------------
    // Serial engine, quarter-bit paced; a held-low clock stretches
    tick = (q.qcnt == 8'(QCYC - 1));
    if (q.ist != PMHS_I_IDLE)
    begin
      if (!tick)
        d.qcnt = q.qcnt + 8'h01;
      else if (!(q.phase[1] && !q.scl_oe && !q.sc_s[1]))
      begin
        d.qcnt  = 8'h00;
        d.phase = q.phase + 2'h1;
        np      = q.phase + 2'h1;
      end
      else
      begin
        tick = 1'b0;
      end
    end
    unique case (q.ist)
      PMHS_I_IDLE:
      begin
        d.qcnt  = 8'h00;
        d.phase = 2'h0;
      end
      PMHS_I_START:
      if (tick)
      begin
        // Data already low with clock high: pull clock, send address
        d.scl_oe = 1'b1;
        d.ist    = PMHS_I_BITS;
        d.phase  = 2'h0;
        d.shreg  = {DEV_ADDR, 1'b0};
      end
      PMHS_I_BITS:
      if (tick)
      begin
        if (np == 2'h1)
          d.sda_oe = ~q.shreg[7];
        else if (np == 2'h2)
          d.scl_oe = 1'b0;
        else if (np == 2'h0)
        begin
          d.scl_oe = 1'b1;
          d.shreg  = {q.shreg[6:0], 1'b0};
          d.bitn   = q.bitn + 3'h1;
          if (q.bitn == 3'h7)
            d.ist = PMHS_I_ACK;
        end
      end
      PMHS_I_ACK:
      if (tick)
      begin
        if (np == 2'h1)
          d.sda_oe = 1'b0;
        else if (np == 2'h2)
          d.scl_oe = 1'b0;
        else if (np == 2'h0)
        begin
          d.scl_oe = 1'b1;
          d.byten  = q.byten + 2'h1;
          nack     = q.sd_s[1];
          if (nack || q.byten == 2'h2)
            d.ist = PMHS_I_STOP;
          else
          begin
            d.shreg = (q.byten == 2'h0) ? q.frame[15:8] : q.frame[7:0];
            d.ist   = PMHS_I_BITS;
          end
          if (nack)
            d.ev[`PMHS_EV_NACK_BIT] = 1'b1;
        end
      end
      PMHS_I_STOP:
      if (tick)
      begin
        if (np == 2'h1)
          d.sda_oe = 1'b1;
        else if (np == 2'h2)
          d.scl_oe = 1'b0;
        else if (np == 2'h3)
          d.sda_oe = 1'b0;
        else
        begin
          d.ist = PMHS_I_IDLE;
          done  = 1'b1;
        end
      end
      default: d.ist = PMHS_I_IDLE;
    endcase

    // ------------------------------------------------
    // Power state machine
    unique case (q.pwr)
      PMHS_RUN:
      if (start)
      begin
        d.pwr  = PMHS_SEQ;
        d.kind = skind;
        d.step = 2'h0;
      end
      PMHS_SEQ:
      begin
        if (start)
          d.ev[`PMHS_EV_REFUSE_BIT] = 1'b1;
        if (q.ist == PMHS_I_IDLE && !done)
        begin
          if (q.step == step_count(q.kind))
          begin
            // All writes through; aux off always precedes hold drop
            d.pwr = PMHS_RUN;
            if (q.kind == PMHS_K_AUX)
            begin
              d.hold = 1'b0;
              d.pwr  = PMHS_BACKUP;
            end
            else if (q.kind == PMHS_K_PSM)
              d.psm_on = 1'b1;
            else if (q.kind == PMHS_K_PWM)
              d.psm_on = 1'b0;
          end
          else
          begin
            d.frame  = step_bytes(q.kind, q.step, q.man_reg, q.man_data);
            d.step   = q.step + 2'h1;
            d.ist    = PMHS_I_START;
            d.sda_oe = 1'b1;
            d.bitn   = 3'h0;
            d.byten  = 2'h0;
          end
        end
        // A refused write aborts the sequence; hold stays up
        // Retag as a one-write manual job so the hold drop is skipped,
        // even when an older no-ack event was never cleared
        if (nack)
        begin
          d.step = 2'h1;
          d.kind = PMHS_K_MAN;
        end
      end
      PMHS_BACKUP:
      begin
        if (start)
          d.ev[`PMHS_EV_REFUSE_BIT] = 1'b1;
        // Wake raises hold; the pin wakes on its rising edge, the alarm on its level
        if ((q.en_pin && q.wk_s[1] && !q.wk_s[2]) || (q.en_rtc && rtc_alarm_i))
        begin
          d.hold   = 1'b1;
          d.psm_on = 1'b0;
          d.pwr    = PMHS_RUN;
        end
      end
      default: d.pwr = PMHS_RUN;
    endcase
    // Refused start from run while engine is busy never happens: run means idle
  end

  // ==================================================
  // State register; hold comes up high out of reset
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q      <= '0;
      q.hold <= 1'b1;
      q.wk_s <= 3'h0;
      q.al_s <= 3'h7;
      q.rs_s <= `PMHS_SYNC_RST;
      q.sd_s <= 2'h3;
      q.sc_s <= 2'h3;
    end
    else
    begin
      q <= d;
    end
  end

  // ==================================================
  // Outputs from the state register; both serial drive values tied low
  assign apb_o               = q.rsp;
  assign host_shutdown_out_o = q.hold;
  assign scl_out_o           = 1'b0;
  assign scl_oe_o            = q.scl_oe;
  assign sda_out_o           = 1'b0;
  assign sda_oe_o            = q.sda_oe;

endmodule // pmhs_host

// ==== tb/pmhs_host_props.sv ====
// Port checker of the sequencer host, bound to its top module
`timescale 1ns/1ps
module pmhs_props (
  input wire logic                    mclk_i,
  input wire logic                    rst_n_i,
  input wire pmhs_pkg::pmhs_apb_req_t apb_i,
  input wire pmhs_pkg::pmhs_apb_rsp_t apb_o,
  input wire logic                    host_shutdown_out_o,
  input wire logic                    wake_pin_i,
  input wire logic                    rtc_alarm_i,
  input wire logic                    scl_out_o,
  input wire logic                    scl_oe_o,
  input wire logic                    sda_out_o,
  input wire logic                    sda_oe_o
);
  import pmhs_pkg::*;
  // ====================
  // Helper logic
  logic [1:0] starts_q;    // Serial starts since the last CTRL write or hold rise
  logic [3:0] wake_age_q;  // Cycles since a wake source was high
  wire        ctrl_wr = apb_o.pready && apb_i.pwrite && apb_i.paddr == 8'h00;
  // Count start conditions so a power-off can be tied to the frames ahead of it
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      starts_q <= 2'h0;
    else if (ctrl_wr || $rose(host_shutdown_out_o))
      starts_q <= 2'h0;
    else if ($rose(sda_oe_o) && !scl_oe_o && starts_q != 2'h3)
      starts_q <= starts_q + 2'h1;
  // Age of the last wake request, saturating so it never wraps back to young
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      wake_age_q <= 4'hF;
    else if (wake_pin_i || rtc_alarm_i)
      wake_age_q <= 4'h0;
    else if (wake_age_q != 4'hF)
      wake_age_q <= wake_age_q + 4'h1;
  // ====================
  // Assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  pready_pulse_a: assert property (apb_o.pready |=> !apb_o.pready)
    else $error("pready stood longer than one cycle");
  access_wait_a: assert property (apb_i.psel && $rose(apb_i.penable) |=> apb_o.pready)
    else $error("pready not one cycle after first access cycle");
  unmapped_err_a: assert property (apb_o.pready && apb_i.paddr >= 8'h10 |-> apb_o.pslverr)
    else $error("unmapped access not flagged");
  mapped_ok_a: assert property (apb_o.pready && apb_i.paddr < 8'h10 && apb_i.paddr[1:0] == 2'h0
    |-> !apb_o.pslverr) else $error("mapped access flagged");
  open_drain_a: assert property (!scl_out_o && !sda_out_o)
    else $error("serial line driven high");
  refuse_hold_a: assert property (ctrl_wr && apb_i.pwdata[0] && apb_i.pwdata[2:1] == 2'h0
    && host_shutdown_out_o |=> host_shutdown_out_o [*8]) else $error("hold dropped no wake");
  aux_first_a: assert property ($fell(host_shutdown_out_o) |-> starts_q >= 2'h2)
    else $error("hold dropped before two serial frames");
  wake_hold_a: assert property ($rose(host_shutdown_out_o) |-> wake_age_q < 4'h8)
    else $error("hold rose without a wake source");
  hold_fall_c: cover property ($fell(host_shutdown_out_o));
  hold_rise_c: cover property ($rose(host_shutdown_out_o));
  slv_err_c: cover property (apb_o.pready && apb_o.pslverr);
endmodule // pmhs_props

bind pmhs_host pmhs_props u_props (.mclk_i, .rst_n_i, .apb_i, .apb_o, .host_shutdown_out_o,
  .wake_pin_i, .rtc_alarm_i, .scl_out_o, .scl_oe_o, .sda_out_o, .sda_oe_o);

// ==== tb/pmhs_dev_model.sv ====
// Behavioural power management device facing the host
`timescale 1ns/1ps
`include "pmhs_map.svh"
module pmhs_dev_model #(
  parameter int RDLY = 40  // Reset release delay, shortened from the real figure
) (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic hold_i,
  input  wire logic supply_ok_i,
  input  wire logic undervolt_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_pull_o,
  output logic      reset_n_o,
  output logic      alarm_n_o,
  output logic      rails_on_o
);
  // ====================
  // Power state
  logic       on_q;             // Main rails up
  int         cnt_q;            // Cycles since rails came up
  logic [7:0] regs [0:7];       // Device registers
  logic [7:0] sh_q, reg_q;      // Shift register and latched register address
  logic [3:0] bit_q;            // Bits of the current byte
  logic [1:0] idx_q, s_q;       // Byte index in frame, last line levels
  int         n_wr, bad_order;  // Writes taken, writes seen after hold fell
  assign rails_on_o = on_q;
  assign reset_n_o  = on_q && cnt_q == RDLY;
  assign alarm_n_o  = !(on_q && undervolt_i);
  // Hold high with a good supply starts the rails, hold low kills all at once
  always @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      {on_q, cnt_q} <= '0;
    else if (!hold_i)
      {on_q, cnt_q} <= '0;
    else if (!on_q)
      on_q <= supply_ok_i;
    else if (cnt_q != RDLY)
      cnt_q <= cnt_q + 1;
  // ====================
  // Serial slave, sampled on the system clock
  always @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      for (int i = 0; i < 8; i++)
        regs[i] <= (i >= 3 && i <= 5) ? 8'h01 : 8'h00;
      {s_q, bit_q, idx_q, sda_pull_o, n_wr, bad_order} <= {2'h3, 7'h0, 64'h0};
    end
    else
    begin
      s_q <= {scl_i, sda_i};
      if (scl_i && s_q == 2'h3 && !sda_i)
        {bit_q, idx_q} <= '0;
      else if (scl_i && !s_q[1])
        {sh_q, bit_q} <= {sh_q[6:0], sda_i, bit_q + 4'h1};
      else if (!scl_i && s_q[1])
      begin
        // Acknowledge only our own address, then every later byte
        sda_pull_o <= bit_q == 4'h8 && (idx_q != 2'h0 || sh_q == {`PMHS_DEV_ADDR, 1'b0});
        if (bit_q == 4'h8)
        begin
          {bit_q, idx_q} <= {4'hF, idx_q + 2'h1};
          if (idx_q == 2'h1)
            reg_q <= sh_q;
          if (idx_q == 2'h2)
          begin
            regs[reg_q[2:0]] <= sh_q;
            n_wr <= n_wr + 1;
            if (!hold_i)
              bad_order <= bad_order + 1;
          end
        end
      end
    end
endmodule // pmhs_dev_model

// ==== tb/test_pmhs_host.sv ====
// Self-checking bench of the sequencer host against the device model
`timescale 1ns/1ps
module test_pmhs_host;
  import pmhs_pkg::*;
  logic          mclk_i = 1'b0;
  logic          rst_n_i = 1'b0;
  pmhs_apb_req_t req = '0;
  pmhs_apb_rsp_t rsp;
  logic          hold, scl_oe, sda_oe, pull, sys_rst_n, alarm_n;
  logic          wake = 1'b0, rtc = 1'b0, uv = 1'b0;
  wire           scl_l = !scl_oe;           // Pull-up: released line reads high
  wire           sda_l = !(sda_oe || pull);
  int            n_mismatch = 0, comparisons = 0, m, r;
  logic [31:0]   rd_v;
  logic          err_v;
  always #5 mclk_i = ~mclk_i;
  // ====================
  // Design and far side
  pmhs_host uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .apb_i(req), .apb_o(rsp),
    .host_shutdown_out_o(hold), .wake_pin_i(wake), .rtc_alarm_i(rtc),
    .alarm_interrupt_n_i(alarm_n), .system_reset_out_n_i(sys_rst_n), .scl_in_i(scl_l),
    .scl_out_o(), .scl_oe_o(scl_oe), .sda_in_i(sda_l), .sda_out_o(), .sda_oe_o(sda_oe));
  pmhs_dev_model dev (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .hold_i(hold), .supply_ok_i(1'b1),
    .undervolt_i(uv), .scl_i(scl_l), .sda_i(sda_l), .sda_pull_o(pull),
    .reset_n_o(sys_rst_n), .alarm_n_o(alarm_n), .rails_on_o());
  // ====================
  // Tasks
  task wrap_up;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task stuck;
    n_mismatch++;
    $display("BAD %0t wait ran out", $time);
    wrap_up;
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk_i);
    req.penable <= 1'b1;
    for (i = 0; i < 20 && rsp.pready !== 1'b1; i++)
      @(posedge mclk_i);
    if (i == 20)
      stuck;
    {rd_v, err_v} = {rsp.prdata, rsp.pslverr};
    req <= '0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk(rd_v, exp);
    chk(32'(err_v), 32'(e));
  endtask
  // Wait for a level on hold (0) or on the device reset (1)
  task wait_for(input int s, input logic v);
    int i;
    for (i = 0; i < 30000 && (s == 0 ? hold : sys_rst_n) !== v; i++)
      @(posedge mclk_i);
    if (i == 30000)
      stuck;
  endtask
  // Wait until the device took n writes and the serial engine went idle
  task wait_done(input int n);
    int i;
    for (i = 0; i < 30000 && dev.n_wr < n; i++)
      @(posedge mclk_i);
    for (i = 0; i < 500; i++)
    begin
      apb(1'b0, 8'h04, 32'h0);
      if (rd_v[3] === 1'b0)
        break;
    end
    if (i == 500 || dev.n_wr != n)
      stuck;
  endtask
  // ====================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    chk(32'(hold), 32'h1);
    wait_for(1, 1'b1);
    rd(8'h04, 32'h34, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    apb(1'b1, 8'h00, 32'h1);
    rd(8'h08, 32'h4, 1'b0);
    chk(32'(hold), 32'h1);
    apb(1'b1, 8'h08, 32'h4);
    rd(8'h08, 32'h0, 1'b0);
    // Saving mode first, then back to fixed frequency
    for (m = 0; m < 2; m++)
    begin
      apb(1'b1, 8'h00, m ? 32'h20 : 32'h10);
      wait_done(3 * m + 3);
      for (r = 3; r < 6; r++)
        chk(32'(dev.regs[r]), m ? 32'h1 : 32'h0);
      rd(8'h04, m ? 32'h34 : 32'h74, 1'b0);
    end
    apb(1'b1, 8'h0C, 32'h01A5);
    wait_done(7);
    chk(32'(dev.regs[1]), 32'hA5);
    rd(8'h0C, 32'h01A5, 1'b0);
    apb(1'b1, 8'h00, 32'h3);
    wait_done(9);
    wait_for(0, 1'b0);
    @(posedge mclk_i);
    chk(32'(sys_rst_n), 32'h0);
    chk({dev.regs[1], dev.regs[2]}, 32'h0);
    chk(32'(dev.bad_order), 32'h0);
    // Power-off must go through the hold line, never a register write at 0x00
    chk(32'(dev.regs[0]), 32'h0);
    rd(8'h04, 32'h23, 1'b0);
    wake <= 1'b1;
    wait_for(0, 1'b1);
    wake <= 1'b0;
    wait_for(1, 1'b1);
    apb(1'b1, 8'h00, 32'hC);
    uv <= 1'b1;
    wait_done(11);
    wait_for(0, 1'b0);
    rd(8'h08, 32'h1, 1'b0);
    uv <= 1'b0;
    rtc <= 1'b1;
    @(posedge mclk_i);
    rtc <= 1'b0;
    wait_for(0, 1'b1);
    wrap_up;
  end
endmodule // test_pmhs_host
